// ---- rtl/pos_pkg.sv ----
`default_nettype none

package pos_pkg;

  // Timebase
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CLK_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S = 1000;

  // Step pulse high time, rounded up to whole cycles
  localparam int unsigned PULSE_HIGH_NS = 2000;
  localparam int unsigned PULSE_HIGH_CYC = (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PULSE_HIGH_CNT = 8'(PULSE_HIGH_CYC);

  // Braking distance scale: two times ms per second
  localparam logic [63:0] BRAKE_SCALE = 64'h0000_0000_0000_07D0;

  // Creep rate held while closing on a target, pls/s
  localparam logic [15:0] FLOOR_RATE = 16'h000A;

  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_NO_ORIGIN = 8'hEA;

  // Values after reset
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DWELL = 3'b100
  } axis_state_t;

  typedef struct packed {
    logic coord_abs;
    logic ctrl_speed;
    logic signed [31:0] address;
    logic [15:0] speed;
    logic [15:0] accel_ms;
    logic [15:0] decel_ms;
    logic [15:0] dwell_ms;
    logic [7:0] aux_code;
  } op_data_t;

  typedef struct packed {
    logic pulse;
    logic dir;
  } motor_out_t;

endpackage

`default_nettype wire

// ---- rtl/step_pulse_gen.sv ----
`timescale 1ns/100ps
`default_nettype none

module step_pulse_gen #(
  parameter int unsigned CYC_PER_MS = pos_pkg::CLK_PER_MS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic [15:0] target_rate_in,
  input wire logic [15:0] ramp_speed_in,
  input wire logic [15:0] accel_ms_in,
  input wire logic [15:0] decel_ms_in,
  // Result
  output logic step_out,
  output logic [15:0] rate_out
);

  localparam logic [31:0] MODULUS = 32'(CYC_PER_MS * pos_pkg::MS_PER_S);
  localparam logic [47:0] CYC_W = 48'(CYC_PER_MS);

  logic [15:0] rate_q, rate_d;
  logic [47:0] frac_q, frac_d;
  logic [31:0] acc_q, acc_d;
  logic step_q, step_d;

  always_comb begin
    logic up;
    logic [15:0] ms;
    logic [47:0] den;
    logic [47:0] sum;
    logic [31:0] acc_sum;
    up = 1'b0;
    ms = 16'h0000;
    den = 48'h0;
    sum = 48'h0;
    acc_sum = 32'h0;
    rate_d = rate_q;
    frac_d = frac_q;
    acc_d = acc_q;
    step_d = 1'b0;
    if (!run_in) begin
      rate_d = pos_pkg::RATE_RESET;
      frac_d = 48'h0;
      acc_d = 32'h0;
    end else begin
      // Linear ramp: ramp_speed increments spread over ms*CYC_PER_MS cycles
      if (rate_q != target_rate_in) begin
        up = rate_q < target_rate_in;
        ms = up ? accel_ms_in : decel_ms_in;
        den = 48'(ms) * CYC_W;
        if (ms == 16'h0000) begin
          rate_d = target_rate_in;
          frac_d = 48'h0;
        end else begin
          sum = frac_q + 48'(ramp_speed_in);
          if (sum >= den) begin
            frac_d = sum - den;
            rate_d = up ? rate_q + 16'h0001 : rate_q - 16'h0001;
          end else begin
            frac_d = sum;
          end
        end
      end else begin
        frac_d = 48'h0;
      end
      // Rate in pls/s against a one-second modulus gives exact average rate
      acc_sum = acc_q + 32'(rate_q);
      if (acc_sum >= MODULUS) begin
        acc_d = acc_sum - MODULUS;
        step_d = 1'b1;
      end else begin
        acc_d = acc_sum;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rate_q <= pos_pkg::RATE_RESET;
      frac_q <= 48'h0;
      acc_q <= 32'h0;
      step_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      frac_q <= frac_d;
      acc_q <= acc_d;
      step_q <= step_d;
    end
  end

  assign step_out = step_q;
  assign rate_out = rate_q;

endmodule // step_pulse_gen

`default_nettype wire

// ---- rtl/pulse_positioning_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module pulse_positioning_control #(
  parameter int unsigned CYC_PER_MS = pos_pkg::CLK_PER_MS
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Commands from the program
  input wire logic START_IN,
  input wire logic DECELERATING_STOP_IN,
  input wire logic EMERGENCY_STOP_IN,
  input wire logic SWITCH_IN,
  input wire logic AUX_CLEAR_IN,
  input wire pos_pkg::op_data_t OP_DATA_IN,
  // Origin from home return
  input wire logic HOME_DONE_IN,
  input wire logic [31:0] HOME_ADDR_IN,
  // Output configuration
  input wire logic LOW_ACTIVE_IN,
  // Motor driver
  output pos_pkg::motor_out_t MOTOR_OUT,
  // Status
  output logic MOVING_OUT,
  output logic COMPLETE_OUT,
  output logic [7:0] ERR_CODE_OUT,
  output logic signed [31:0] POSITION_OUT,
  output logic AUX_FLAG_OUT,
  output logic [7:0] AUX_CODE_OUT
);

  localparam logic [31:0] MS_LAST = 32'(CYC_PER_MS - 1);

  pos_pkg::axis_state_t state_q, state_d;
  pos_pkg::op_data_t op_q, op_d;
  logic signed [31:0] pos_q, pos_d;
  logic signed [31:0] target_q, target_d;
  logic speed_mode_q, speed_mode_d;
  logic rev_q, rev_d;
  logic stopping_q, stopping_d;
  logic origin_q, origin_d;
  logic [7:0] err_q, err_d;
  logic complete_q, complete_d;
  logic aux_flag_q, aux_flag_d;
  logic [7:0] aux_code_q, aux_code_d;
  logic [15:0] dwell_q, dwell_d;
  logic [31:0] ms_cnt_q, ms_cnt_d;
  logic start_prev_q;
  logic [7:0] pulse_cnt_q, pulse_cnt_d;
  pos_pkg::motor_out_t motor_q, motor_d;

  logic step;
  logic [15:0] rate;
  logic [15:0] target_rate;
  logic [15:0] floor_rate;
  logic signed [32:0] diff;
  logic [32:0] remaining;
  logic [63:0] brake_lhs;
  logic [63:0] brake_rhs;
  logic brake;
  logic start_edge;
  logic step_taken;

  assign start_edge = START_IN & ~start_prev_q;

  // Distance left and the distance needed to ramp down from the present rate
  assign diff = 33'(target_q) - 33'(pos_q);
  assign remaining = diff[32] ? 33'(-diff) : 33'(diff);
  assign brake_lhs = 64'(remaining) * pos_pkg::BRAKE_SCALE * 64'(op_q.speed);
  assign brake_rhs = 64'(rate) * 64'(rate) * 64'(op_q.decel_ms);
  assign brake = !speed_mode_q && (brake_lhs <= brake_rhs);

  // Creep keeps a position move from stalling short of the target
  assign floor_rate = (op_q.speed < pos_pkg::FLOOR_RATE) ? op_q.speed : pos_pkg::FLOOR_RATE;

  always_comb begin
    if (stopping_q) begin
      target_rate = 16'h0000;
    end else if (brake) begin
      target_rate = floor_rate;
    end else begin
      target_rate = op_q.speed;
    end
  end

  step_pulse_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_gen (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .run_in(state_q == pos_pkg::ST_RUN),
    .target_rate_in(target_rate),
    .ramp_speed_in(op_q.speed),
    .accel_ms_in(op_q.accel_ms),
    .decel_ms_in(op_q.decel_ms),
    .step_out(step),
    .rate_out(rate)
  );

  // Steps past the target or after the state has moved on are dropped
  assign step_taken = step && (state_q == pos_pkg::ST_RUN) && !EMERGENCY_STOP_IN &&
                      (speed_mode_q || (remaining != 33'h0));

  always_comb begin
    logic signed [31:0] addr_mag;
    logic signed [31:0] next_pos;
    addr_mag = OP_DATA_IN.address;
    next_pos = pos_q;
    state_d = state_q;
    op_d = op_q;
    pos_d = pos_q;
    target_d = target_q;
    speed_mode_d = speed_mode_q;
    rev_d = rev_q;
    stopping_d = stopping_q;
    origin_d = origin_q;
    err_d = err_q;
    complete_d = 1'b0;
    aux_flag_d = aux_flag_q;
    aux_code_d = aux_code_q;
    dwell_d = dwell_q;
    ms_cnt_d = ms_cnt_q;
    if (AUX_CLEAR_IN) begin
      aux_flag_d = 1'b0;
      aux_code_d = 8'h00;
    end
    case (state_q)
      pos_pkg::ST_IDLE: begin
        if (HOME_DONE_IN) begin
          origin_d = 1'b1;
          pos_d = HOME_ADDR_IN;
        end else if (start_edge) begin
          if (!origin_q) begin
            err_d = pos_pkg::ERR_NO_ORIGIN;
          end else begin
            err_d = pos_pkg::ERR_NONE;
            op_d = OP_DATA_IN;
            stopping_d = 1'b0;
            speed_mode_d = OP_DATA_IN.ctrl_speed;
            if (OP_DATA_IN.ctrl_speed) begin
              rev_d = OP_DATA_IN.address[31];
              target_d = pos_q;
              state_d = pos_pkg::ST_RUN;
            end else begin
              if (OP_DATA_IN.coord_abs) begin
                target_d = OP_DATA_IN.address;
                rev_d = OP_DATA_IN.address < pos_q;
              end else begin
                target_d = pos_q + OP_DATA_IN.address;
                rev_d = OP_DATA_IN.address[31];
              end
              if (target_d == pos_q) begin
                state_d = pos_pkg::ST_DWELL;
                dwell_d = 16'h0000;
                ms_cnt_d = 32'h0;
              end else begin
                state_d = pos_pkg::ST_RUN;
              end
            end
          end
        end
      end
      pos_pkg::ST_RUN: begin
        if (step_taken) begin
          next_pos = rev_q ? pos_q - 32'sd1 : pos_q + 32'sd1;
          pos_d = next_pos;
        end
        if (EMERGENCY_STOP_IN) begin
          state_d = pos_pkg::ST_IDLE;
          stopping_d = 1'b0;
        end else if (stopping_q) begin
          if (rate == 16'h0000) begin
            state_d = pos_pkg::ST_IDLE;
            stopping_d = 1'b0;
          end
        end else if (DECELERATING_STOP_IN) begin
          stopping_d = 1'b1;
        end else if (speed_mode_q && SWITCH_IN) begin
          // Restart from zero and keep the direction already travelling
          addr_mag = op_q.address[31] ? -op_q.address : op_q.address;
          speed_mode_d = 1'b0;
          pos_d = 32'sd0;
          target_d = rev_q ? -addr_mag : addr_mag;
          if (addr_mag == 32'sd0) begin
            state_d = pos_pkg::ST_DWELL;
            dwell_d = 16'h0000;
            ms_cnt_d = 32'h0;
          end
        end else if (!speed_mode_q && step_taken && (next_pos == target_q)) begin
          state_d = pos_pkg::ST_DWELL;
          dwell_d = 16'h0000;
          ms_cnt_d = 32'h0;
        end
      end
      pos_pkg::ST_DWELL: begin
        if (EMERGENCY_STOP_IN) begin
          state_d = pos_pkg::ST_IDLE;
        end else if (dwell_q == op_q.dwell_ms) begin
          state_d = pos_pkg::ST_IDLE;
          complete_d = 1'b1;
          aux_flag_d = 1'b1;
          aux_code_d = op_q.aux_code;
        end else if (ms_cnt_q == MS_LAST) begin
          ms_cnt_d = 32'h0;
          dwell_d = dwell_q + 16'h0001;
        end else begin
          ms_cnt_d = ms_cnt_q + 32'h1;
        end
      end
      default: begin
        state_d = pos_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      state_q <= pos_pkg::ST_IDLE;
      op_q <= '0;
      pos_q <= pos_pkg::POS_RESET;
      target_q <= pos_pkg::POS_RESET;
      speed_mode_q <= 1'b0;
      rev_q <= 1'b0;
      stopping_q <= 1'b0;
      origin_q <= 1'b0;
      err_q <= pos_pkg::ERR_NONE;
      complete_q <= 1'b0;
      aux_flag_q <= 1'b0;
      aux_code_q <= 8'h00;
      dwell_q <= 16'h0000;
      ms_cnt_q <= 32'h0;
      start_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      pos_q <= pos_d;
      target_q <= target_d;
      speed_mode_q <= speed_mode_d;
      rev_q <= rev_d;
      stopping_q <= stopping_d;
      origin_q <= origin_d;
      err_q <= err_d;
      complete_q <= complete_d;
      aux_flag_q <= aux_flag_d;
      aux_code_q <= aux_code_d;
      dwell_q <= dwell_d;
      ms_cnt_q <= ms_cnt_d;
      start_prev_q <= START_IN;
    end
  end

  // Stretch each step so the driver's optocoupler sees it
  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    if (step_taken) begin
      pulse_cnt_d = pos_pkg::PULSE_HIGH_CNT;
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_d = pulse_cnt_q - 8'h01;
    end
    motor_d.pulse = (pulse_cnt_d != 8'h00) ^ LOW_ACTIVE_IN;
    motor_d.dir = rev_d ^ LOW_ACTIVE_IN;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      pulse_cnt_q <= 8'h00;
      motor_q <= '0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      motor_q <= motor_d;
    end
  end

  assign MOTOR_OUT = motor_q;
  assign MOVING_OUT = (state_q == pos_pkg::ST_RUN);
  assign COMPLETE_OUT = complete_q;
  assign ERR_CODE_OUT = err_q;
  assign POSITION_OUT = pos_q;
  assign AUX_FLAG_OUT = aux_flag_q;
  assign AUX_CODE_OUT = aux_code_q;

endmodule // pulse_positioning_control

`default_nettype wire

// ---- sim/pulse_positioning_control_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module pulse_positioning_control_sva #(
  parameter int unsigned CYC_PER_MS = pos_pkg::CLK_PER_MS
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Commands
  input wire logic START_IN,
  input wire logic EMERGENCY_STOP_IN,
  input wire logic HOME_DONE_IN,
  input wire logic LOW_ACTIVE_IN,
  // Outputs
  input wire pos_pkg::motor_out_t MOTOR_OUT,
  input wire logic MOVING_OUT,
  input wire logic COMPLETE_OUT,
  input wire logic [7:0] ERR_CODE_OUT,
  input wire logic AUX_FLAG_OUT
);
  logic origin_q;
  logic origin_d;
  logic step_act;

  // Polarity folded out so one rule covers both modes
  assign step_act = MOTOR_OUT.pulse ^ LOW_ACTIVE_IN;

  always_comb begin
    origin_d = origin_q | HOME_DONE_IN;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    origin_q <= RST_IN ? 1'b0 : origin_d;
  end

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_start_edge;
    !START_IN ##1 START_IN;
  endsequence

  sequence s_single;
    COMPLETE_OUT ##1 !COMPLETE_OUT;
  endsequence

  a_no_origin_err: assert property (s_start_edge ##0 !origin_q |=> ERR_CODE_OUT == 8'hEA)
    else $error("start without origin gave no error code");
  a_err_no_motion: assert property (ERR_CODE_OUT == 8'hEA |-> !MOVING_OUT)
    else $error("moving while origin error stands");
  a_complete_single: assert property ($rose(COMPLETE_OUT) |-> s_single)
    else $error("complete longer than one scan");
  a_complete_aux: assert property (COMPLETE_OUT |-> AUX_FLAG_OUT && !MOVING_OUT)
    else $error("complete without aux flag or while moving");
  a_step_when_moving: assert property ($rose(step_act) && $stable(LOW_ACTIVE_IN) |-> $past(MOVING_OUT))
    else $error("step pulse while not moving");
  a_dir_hold: assert property (step_act && $past(step_act) && $stable(LOW_ACTIVE_IN) |-> $stable(MOTOR_OUT.dir))
    else $error("direction changed during a step");
  a_emg_halt: assert property (EMERGENCY_STOP_IN && MOVING_OUT |=> !MOVING_OUT)
    else $error("emergency stop did not halt");
  a_moving_cause: assert property ($rose(MOVING_OUT) |-> $past(START_IN) && !$past(START_IN, 2))
    else $error("motion began without a start edge");
endmodule // pulse_positioning_control_sva

`default_nettype wire

// ---- sim/step_counter_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module step_counter_model (
  // Clock
  input wire logic clk_in,
  // Driver inputs
  input wire pos_pkg::motor_out_t motor_in,
  input wire logic low_active_in,
  // Counted travel
  output logic signed [31:0] count_out
);
  logic step_q;
  logic step_now;
  logic rev;

  assign step_now = motor_in.pulse ^ low_active_in;
  assign rev = motor_in.dir ^ low_active_in;

  initial begin
    count_out = 32'sh0000_0000;
    step_q = 1'b0;
  end

  // Driver counts on the leading edge of each step
  always @(posedge clk_in) begin
    if (step_now && !step_q) begin
      count_out <= rev ? count_out - 1 : count_out + 1;
    end
    step_q <= step_now;
  end
endmodule // step_counter_model

`default_nettype wire

// ---- sim/tb_pulse_positioning_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_pulse_positioning_control;
  logic clk, rst, start, dstop, estop, sw, aclr, home, low;
  logic [31:0] haddr;
  pos_pkg::op_data_t op;
  pos_pkg::motor_out_t motor;
  logic moving, done, auxf;
  logic [7:0] err, auxc;
  logic signed [31:0] pos, cnt, c0;
  int miscompares, n_checks, cyc, ndone, n, i, t0;

  pulse_positioning_control #(.CYC_PER_MS(50)) uut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .START_IN(start), .DECELERATING_STOP_IN(dstop),
    .EMERGENCY_STOP_IN(estop), .SWITCH_IN(sw), .AUX_CLEAR_IN(aclr), .OP_DATA_IN(op),
    .HOME_DONE_IN(home), .HOME_ADDR_IN(haddr), .LOW_ACTIVE_IN(low), .MOTOR_OUT(motor),
    .MOVING_OUT(moving), .COMPLETE_OUT(done), .ERR_CODE_OUT(err), .POSITION_OUT(pos),
    .AUX_FLAG_OUT(auxf), .AUX_CODE_OUT(auxc));

  step_counter_model drv (.clk_in(clk), .motor_in(motor), .low_active_in(low), .count_out(cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard, runs far past the expected length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  always @(negedge clk) begin
    if (done === 1'b1) ndone++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic go(input logic ab, input logic sp, input logic signed [31:0] ad,
                    input logic [15:0] dc);
    op.coord_abs = ab;
    op.ctrl_speed = sp;
    op.address = ad;
    op.decel_ms = dc;
    c0 = cnt;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(1);
  endtask

  task automatic wait_done(input logic signed [31:0] p, input logic [7:0] ac);
    for (i = 0; i < 5000 && done !== 1'b1; i++) tick(1);
    chk("complete", done, 1);
    chk("aux_flag", auxf, 1);
    chk("aux_code", auxc, ac);
    chk("position", pos, p);
    tick(1);
    chk("complete_drop", done, 0);
  endtask

  task automatic move(input logic ab, input logic signed [31:0] ad, input logic signed [31:0] p,
                      input logic dr, input logic signed [31:0] st);
    go(ab, 1'b0, ad, 16'h0000);
    chk("dir", motor.dir, dr);
    wait_done(p, op.aux_code);
    chk("steps", cnt - c0, st);
    tick(300);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    {start, dstop, estop, sw, aclr, home, low} = '0;
    rst = 1'b1;
    haddr = 32'h0000_000A;
    op = '0;
    op.speed = 16'h00C8;
    op.dwell_ms = 16'h0002;
    op.aux_code = 8'h07;
    tick(8);
    rst = 1'b0;
    go(1'b1, 1'b0, 5, 16'h0000);
    chk("err_pos", err, 8'hEA);
    chk("still_pos", moving, 0);
    go(1'b0, 1'b1, 5, 16'h0000);
    chk("err_spd", err, 8'hEA);
    chk("still_spd", moving, 0);
    home = 1'b1;
    tick(1);
    home = 1'b0;
    tick(1);
    chk("home", pos, 32'h0000_000A);
    move(1'b1, 13, 13, 1'b0, 3);
    chk("err_clr", err, 0);
    move(1'b0, -3, 10, 1'b1, -3);
    move(1'b1, 8, 8, 1'b1, -2);
    low = 1'b1;
    tick(2);
    chk("idle_low", motor.pulse, 1);
    move(1'b0, 2, 10, 1'b1, 2);
    low = 1'b0;
    aclr = 1'b1;
    tick(1);
    aclr = 1'b0;
    tick(1);
    chk("aux_clr", auxf, 0);
    op.aux_code = 8'h09;
    // Absolute target below position, yet sign says forward
    go(1'b1, 1'b1, 1, 16'h0014);
    tick(600);
    chk("spd_dir", motor.dir, 0);
    chk("spd_up", pos > 32'sh0000_000A, 1);
    n = ndone;
    dstop = 1'b1;
    tick(200);
    chk("decel_ramp", moving, 1);
    for (i = 0; i < 3000 && moving !== 1'b0; i++) tick(1);
    // Full ramp from 200 pls/s over 20 ms is about 1000 cycles at this scale
    chk("decel_time", i > 700 && i < 900, 1);
    dstop = 1'b0;
    chk("stopped", moving, 0);
    tick(200);
    chk("no_complete", ndone, n);
    chk("no_aux", auxf, 0);
    go(1'b0, 1'b1, -1, 16'h0000);
    tick(400);
    estop = 1'b1;
    tick(1);
    estop = 1'b0;
    chk("emg", moving, 0);
    tick(200);
    chk("emg_no_done", ndone, n);
    go(1'b0, 1'b1, 3, 16'h0000);
    tick(400);
    sw = 1'b1;
    tick(1);
    sw = 1'b0;
    chk("switch_zero", pos, 0);
    wait_done(3, 8'h09);
    // Ramped position move: slow start and braking to creep near the target
    op.accel_ms = 16'h000A;
    t0 = cyc;
    go(1'b0, 1'b0, 4, 16'h000A);
    wait_done(7, 8'h09);
    chk("ramp_steps", cnt - c0, 4);
    chk("ramp_time", (cyc - t0) > 1300, 1);
    complete_run();
  end
endmodule // tb_pulse_positioning_control

bind pulse_positioning_control pulse_positioning_control_sva #(.CYC_PER_MS(CYC_PER_MS)) chk_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .START_IN(START_IN), .EMERGENCY_STOP_IN(EMERGENCY_STOP_IN),
  .HOME_DONE_IN(HOME_DONE_IN), .LOW_ACTIVE_IN(LOW_ACTIVE_IN), .MOTOR_OUT(MOTOR_OUT),
  .MOVING_OUT(MOVING_OUT), .COMPLETE_OUT(COMPLETE_OUT), .ERR_CODE_OUT(ERR_CODE_OUT),
  .AUX_FLAG_OUT(AUX_FLAG_OUT));

`default_nettype wire
